// file: aph_host_port.sv
// Parallel host port of a 12-bit plus sign sampling converter: bus pins,
// configuration word, result reads, sync pin, ready and standby outputs.
// Assumes CLK is also the converter clock and the converter core
// answers start pulses with CONV_DONE and CONV_RESULT on the same clock.
//
// Function
// - The write edge strap is caught after reset; low latches on the write rising edge, high on falling.
// - With sync bit set the sync pin is an input and its rising edge starts a conversion.
// - With sync bit clear the sync pin is driven high during each conversion and low after it.
// - With bus width bit clear only the low eight data lines are active, otherwise all thirteen.
// - The data bus is thirteen bits wide with line 12 as most significant bit.
// - Input buffers are enabled only while chip select and write are low, and data is latched on the chosen edge.
// - The bus is driven only while chip select and read are low.
// - The active-low ready output marks when a requested function begins and ends.
// - Standby status is low in standby and high once out of it or once leaving is requested.
// - The four channel-select bits route analog channels to the multiplexer outputs.
// - In 8-bit mode a write to the upper byte clears the upper byte select flag.
// - In 8-bit mode the first read gives the lower result byte and the next the upper byte.
// - At power-up the sync pin is an input.
// - At power-up the bus width is 8 bits.
`timescale 1ns/1ps

module aph_host_port (
	input  wire logic           CLK,
	input  wire logic           RESET,
	input  wire logic           WRITE_EDGE_SELECT_STRAP,
	input  wire logic           CS_N,
	input  wire logic           WR_N,
	input  wire logic           RD_N,
	input  wire aph_pkg::aph_word_t DATA_BUS_LINES_IN,
	output aph_pkg::aph_word_t  DATA_BUS_LINES_OUT,
	output aph_pkg::aph_word_t  DATA_BUS_LINES_OE,
	output logic                DATA_INPUT_ENABLE,
	input  wire logic           SYNC_IN,
	output logic                SYNC_OUT,
	output logic                SYNC_OE,
	output logic                READY_N,
	output logic                STANDBY_STATUS_N,
	output aph_pkg::aph_chan_t  MUX_POSITIVE_OUTPUT,
	output aph_pkg::aph_chan_t  MUX_NEGATIVE_OUTPUT,
	output logic                MUX_NEGATIVE_PSEUDO_GROUND,
	output aph_pkg::aph_cmd_t   COMMAND_CODE,
	output logic                COMMAND_STROBE,
	input  wire logic           FUNCTION_DONE,
	output logic                CONV_START,
	input  wire logic           CONV_DONE,
	input  wire aph_pkg::aph_word_t CONV_RESULT
);
	import aph_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic            cs_n_s;
	logic            wr_n_s;
	logic            rd_n_s;
	logic            strap_s;
	logic            sync_s;
	aph_word_t       data_s;
	logic            wr_n_q;
	logic            rd_n_q;
	logic            cs_n_q;
	logic            sync_q;
	aph_word_t       data_q;
	logic            strap_taken;
	logic            latch_on_fall;
	aph_word_t       config_word;
	aph_word_t       next_config;
	aph_word_t       result;
	logic            upper_read;
	logic            write_hit;
	aph_word_t       write_data;
	logic            read_end;
	logic            wide_bus;
	logic            sync_in_mode;
	logic            sync_rise;
	logic            cmd_now;
	aph_cmd_t        cmd_written;
	logic [6:0]      acq_count;
	logic            standby;
	aph_conv_state_t state;
	aph_conv_state_t next_state;

	function automatic logic [6:0] acq_clocks(input logic [1:0] sel);
		unique case (sel)
			2'h0: acq_clocks = `APH_ACQ_CLK_0;
			2'h1: acq_clocks = `APH_ACQ_CLK_1;
			2'h2: acq_clocks = `APH_ACQ_CLK_2;
			2'h3: acq_clocks = `APH_ACQ_CLK_3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	aph_sync2 #(.WIDTH(`APH_WORD_W + 5)) u_pins (
		.CLK    (CLK),
		.PIN    ({DATA_BUS_LINES_IN, CS_N, WR_N, RD_N, WRITE_EDGE_SELECT_STRAP, SYNC_IN}),
		.SYNCED ({data_s, cs_n_s, wr_n_s, rd_n_s, strap_s, sync_s})
	);

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			cs_n_q <= 1'b1;
			sync_q <= 1'b0;
			data_q <= `APH_RESULT_RESET;
		end else begin
			wr_n_q <= wr_n_s;
			rd_n_q <= rd_n_s;
			cs_n_q <= cs_n_s;
			sync_q <= sync_s;
			data_q <= data_s;
		end
	end

	// Strap is taken once after reset, never followed later
	always_ff @(posedge CLK) begin
		if (RESET) begin
			strap_taken   <= 1'b0;
			latch_on_fall <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken   <= 1'b1;
			latch_on_fall <= strap_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign wide_bus          = config_word[`APH_BW_BIT];
	assign sync_in_mode      = config_word[`APH_SYNC_BIT];
	assign DATA_INPUT_ENABLE = !cs_n_s && !wr_n_s;

	// Falling edge: chip select must be low now; rising edge: it was low
	// during the low phase, and data from that phase is used.
	always_comb begin
		if (latch_on_fall) begin
			write_hit  = strap_taken && wr_n_q && !wr_n_s && !cs_n_s;
			write_data = data_s;
		end else begin
			write_hit  = strap_taken && !wr_n_q && wr_n_s && !cs_n_q;
			write_data = data_q;
		end
	end

	// Only writes that reach the command field issue a command; a command
	// acts on the sync and acquisition bits written with it, not the old ones
	always_comb begin
		cmd_now     = 1'b0;
		cmd_written = write_data[`APH_CMD_HI:`APH_CMD_LO];
		next_config = config_word;
		if (write_hit) begin
			if (wide_bus) begin
				cmd_now     = 1'b1;
				next_config = write_data;
			end else if (config_word[`APH_HB_BIT]) begin
				cmd_now     = 1'b1;
				cmd_written = write_data[`APH_CMD_HI-`APH_UPPER_LO:`APH_CMD_LO-`APH_UPPER_LO];
				next_config[`APH_WORD_W-1:`APH_UPPER_LO] = write_data[`APH_UPPER_W-1:0];
				next_config[`APH_HB_BIT]                 = 1'b0;
			end else begin
				next_config[`APH_BYTE_HI:0] = write_data[`APH_BYTE_HI:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			config_word <= `APH_CFG_RESET;
		end else begin
			config_word <= next_config;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			COMMAND_CODE   <= `APH_CMD_STANDBY;
			COMMAND_STROBE <= 1'b0;
		end else begin
			COMMAND_STROBE <= cmd_now;
			if (cmd_now) begin
				COMMAND_CODE <= cmd_written;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign read_end = !rd_n_q && rd_n_s && !cs_n_q;

	// Pointer restarts at the lower byte whenever a new result lands
	always_ff @(posedge CLK) begin
		if (RESET) begin
			upper_read <= 1'b0;
		end else if (CONV_DONE || wide_bus) begin
			upper_read <= 1'b0;
		end else if (read_end) begin
			upper_read <= !upper_read;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			result <= `APH_RESULT_RESET;
		end else if (CONV_DONE) begin
			if (config_word[`APH_SE_BIT] && CONV_RESULT[`APH_WORD_W-1]) begin
				result <= `APH_RESULT_RESET;
			end else begin
				result <= CONV_RESULT;
			end
		end
	end

	// Upper byte carries the sign extended across the unused lines
	always_ff @(posedge CLK) begin
		if (RESET) begin
			DATA_BUS_LINES_OUT <= `APH_RESULT_RESET;
		end else if (wide_bus) begin
			DATA_BUS_LINES_OUT <= result;
		end else if (upper_read) begin
			DATA_BUS_LINES_OUT <= {5'h00, {3{result[`APH_WORD_W-1]}},
				result[`APH_WORD_W-1:`APH_UPPER_LO]};
		end else begin
			DATA_BUS_LINES_OUT <= {5'h00, result[`APH_BYTE_HI:0]};
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			DATA_BUS_LINES_OE <= `APH_RESULT_RESET;
		end else if (!cs_n_s && !rd_n_s) begin
			DATA_BUS_LINES_OE <= wide_bus ? 13'h1FFF : 13'h00FF;
		end else begin
			DATA_BUS_LINES_OE <= `APH_RESULT_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign MUX_POSITIVE_OUTPUT        = config_word[`APH_MUX_HI-1:`APH_MUX_LO];
	assign MUX_NEGATIVE_PSEUDO_GROUND = config_word[`APH_MUX_HI];
	assign MUX_NEGATIVE_OUTPUT        = {config_word[`APH_MUX_HI-1:`APH_MUX_LO+1],
		!config_word[`APH_MUX_LO]};

	////////////////////////////////////////////////////////////////////////////
	assign sync_rise = sync_in_mode && sync_s && !sync_q;

	always_comb begin
		next_state = state;
		unique case (state)
			APH_IDLE: begin
			end
			APH_ACQUIRE: begin
				if (acq_count == 7'h00) begin
					next_state = APH_CONVERT;
				end
			end
			APH_ARMED: begin
				if (sync_rise) begin
					next_state = APH_CONVERT;
				end
			end
			APH_CONVERT: begin
				if (CONV_DONE) begin
					next_state = sync_in_mode ? APH_ARMED : APH_ACQUIRE;
				end
			end
		endcase
		if (cmd_now) begin
			if (cmd_written == `APH_CMD_START) begin
				next_state = next_config[`APH_SYNC_BIT] ? APH_ARMED : APH_ACQUIRE;
			end else begin
				next_state = APH_IDLE;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			state      <= APH_IDLE;
			CONV_START <= 1'b0;
		end else begin
			state      <= next_state;
			CONV_START <= (next_state == APH_CONVERT) && (state != APH_CONVERT);
		end
	end

	// Acquisition window is counted in converter clocks
	always_ff @(posedge CLK) begin
		if (RESET) begin
			acq_count <= 7'h00;
		end else if (next_state == APH_ACQUIRE && state != APH_ACQUIRE) begin
			acq_count <= acq_clocks(next_config[`APH_ACQ_HI:`APH_ACQ_LO]) - 7'h01;
		end else if (state == APH_ACQUIRE && acq_count != 7'h00) begin
			acq_count <= acq_count - 7'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			SYNC_OUT <= 1'b0;
		end else begin
			SYNC_OUT <= !sync_in_mode && (next_state == APH_CONVERT);
		end
	end

	assign SYNC_OE = !sync_in_mode;

	////////////////////////////////////////////////////////////////////////////
	// Power-on command field is standby, so the port starts in standby
	always_ff @(posedge CLK) begin
		if (RESET) begin
			standby <= 1'b1;
		end else if (cmd_now) begin
			standby <= (cmd_written == `APH_CMD_STANDBY);
		end
	end

	assign STANDBY_STATUS_N = !standby;

	// High while a function runs, low when it ends or a result waits
	always_ff @(posedge CLK) begin
		if (RESET) begin
			READY_N <= 1'b1;
		end else if (cmd_now) begin
			READY_N <= (cmd_written != `APH_CMD_RESET);
		end else if (CONV_DONE || FUNCTION_DONE) begin
			READY_N <= 1'b0;
		end else if (CONV_START) begin
			READY_N <= 1'b1;
		end
	end
endmodule

// file: aph_regs.svh
// Constants of the parallel host port: configuration word layout,
// power-on values, command codes and acquisition lengths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef APH_REGS_SVH
`define APH_REGS_SVH

`define APH_WORD_W        13
`define APH_CFG_RESET     13'h0100
`define APH_RESULT_RESET  13'h0000
`define APH_MUX_LO        0
`define APH_MUX_HI        3
`define APH_ACQ_LO        4
`define APH_ACQ_HI        5
`define APH_SE_BIT        6
`define APH_HB_BIT        7
`define APH_SYNC_BIT      8
`define APH_CMD_LO        9
`define APH_CMD_HI        11
`define APH_BW_BIT        12
`define APH_BYTE_HI       7
`define APH_UPPER_LO      8
`define APH_UPPER_W       5
`define APH_ACQ_CLK_0     7'h09
`define APH_ACQ_CLK_1     7'h0F
`define APH_ACQ_CLK_2     7'h2F
`define APH_ACQ_CLK_3     7'h4F
`define APH_CMD_STANDBY   3'h0
`define APH_CMD_FULLCAL   3'h1
`define APH_CMD_AUTOZERO  3'h2
`define APH_CMD_RESET     3'h3
`define APH_CMD_START     3'h4

`endif

// file: aph_pkg.sv
// Types shared by the parallel host port files.
// Assumes aph_regs.svh is on the include path.
`include "aph_regs.svh"

package aph_pkg;
	typedef logic [`APH_WORD_W-1:0] aph_word_t;
	typedef logic [2:0]             aph_cmd_t;
	typedef logic [2:0]             aph_chan_t;
	typedef enum logic [1:0] {
		APH_IDLE,
		APH_ACQUIRE,
		APH_ARMED,
		APH_CONVERT
	} aph_conv_state_t;
endpackage

// file: aph_sync2.sv
// Two-flop synchroniser for pins arriving from outside the clock domain.
// Assumes one clock; no reset, as the stages settle within two edges.
`timescale 1ns/1ps

module aph_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK,
	input  wire logic [WIDTH-1:0] PIN,
	output logic      [WIDTH-1:0] SYNCED
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge CLK) begin
		meta   <= PIN;
		SYNCED <= meta;
	end
endmodule

// file: aph_host_port_asserts.sv
// Pin-level assertions of the parallel host port.
// Assumes binding to aph_host_port; sees only its ports.
`timescale 1ns/1ps

module aph_host_port_asserts (
	input wire logic               CLK,
	input wire logic               RESET,
	input wire logic               CS_N,
	input wire logic               WR_N,
	input wire logic               RD_N,
	input wire aph_pkg::aph_word_t DATA_BUS_LINES_OE,
	input wire logic               DATA_INPUT_ENABLE,
	input wire logic               SYNC_OE,
	input wire logic               SYNC_OUT,
	input wire logic               READY_N,
	input wire logic               STANDBY_STATUS_N,
	input wire aph_pkg::aph_cmd_t  COMMAND_CODE,
	input wire logic               COMMAND_STROBE,
	input wire logic               CONV_START,
	input wire logic               CONV_DONE,
	input wire logic               FUNCTION_DONE
);
	import aph_pkg::*;

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	// Two synchroniser stages and the enable flop sit between pins and bus drive
	chk_oe_cause: assert property ($rose(|DATA_BUS_LINES_OE) |-> !$past(RD_N, 3) && !$past(CS_N, 3))
		else $error("bus driven without read");
	chk_oe_release: assert property (RD_N [*3] |=> DATA_BUS_LINES_OE == 13'h0000)
		else $error("bus still driven after read");
	chk_din_enable: assert property (DATA_INPUT_ENABLE == (!$past(CS_N, 2) && !$past(WR_N, 2)))
		else $error("input enable wrong");
	chk_sync_power: assert property ($fell(RESET) |-> !SYNC_OE)
		else $error("sync pin driven after reset");
	chk_sync_rise: assert property (CONV_START && SYNC_OE |-> SYNC_OUT)
		else $error("sync low at conversion start");
	chk_sync_fall: assert property (CONV_DONE && SYNC_OE |=> !SYNC_OUT)
		else $error("sync high after conversion");
	chk_ready_done: assert property (CONV_DONE || FUNCTION_DONE |=> !READY_N)
		else $error("ready not low after done");
	chk_start_ready: assert property (CONV_START |=> READY_N [*3])
		else $error("ready low during conversion");
	chk_standby_low: assert property (COMMAND_STROBE && COMMAND_CODE == 3'h0 |-> ##2 !STANDBY_STATUS_N)
		else $error("standby status not low");
endmodule

bind aph_host_port aph_host_port_asserts u_chk (.CLK, .RESET, .CS_N, .WR_N, .RD_N,
	.DATA_BUS_LINES_OE, .DATA_INPUT_ENABLE, .SYNC_OE, .SYNC_OUT, .READY_N, .STANDBY_STATUS_N,
	.COMMAND_CODE, .COMMAND_STROBE, .CONV_START, .CONV_DONE, .FUNCTION_DONE);

// file: aph_host_model.sv
// Host bus master model: chip select, strobes and data drive.
// Assumes the bench resolves the bus wire and calls tasks at falling edges.
`timescale 1ns/1ps

module aph_host_model (
	input  wire logic               clk,
	input  wire logic               strap,
	input  wire aph_pkg::aph_word_t bus,
	output logic                    cs_n,
	output logic                    wr_n,
	output logic                    rd_n,
	output logic                    hoe,
	output aph_pkg::aph_word_t      hd
);
	import aph_pkg::*;

	int slow = 0;

	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		hoe = 1'b0;
		hd = '0;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Word valid only around the strapped edge, so a wrong edge latches its inverse
	task automatic wr(input aph_word_t w);
		cs_n = 1'b0;
		hoe = 1'b1;
		hd = strap ? w : ~w;
		gap(4);
		wr_n = 1'b0;
		gap(4);
		hd = strap ? ~w : w;
		gap(4 + slow);
		wr_n = 1'b1;
		gap(4);
		cs_n = 1'b1;
		hoe = 1'b0;
		gap(4);
	endtask

	// Driven lines agree over two samples, released ones toggle
	task automatic rd(output aph_word_t r, output aph_word_t m);
		aph_word_t a;
		cs_n = 1'b0;
		rd_n = 1'b0;
		gap(5 + slow);
		a = bus;
		gap(1);
		r = bus;
		m = ~(a ^ r);
		rd_n = 1'b1;
		gap(4);
		cs_n = 1'b1;
		gap(4);
	endtask
endmodule

// file: aph_host_port_bench.sv
// Self-checking bench of the host port with host and converter core models.
// Assumes the package, host model and bound checker are compiled first.
`timescale 1ns/1ps

module aph_host_port_bench;
	import aph_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        strap = 1'b1;
	logic        sync_in = 1'b0;
	logic        conv_done = 1'b0;
	logic        fn_done = 1'b0;
	aph_word_t   conv_res = '0;
	aph_word_t   flt = 13'h0AAA;
	aph_word_t   bus, d_out, d_oe, hd, r, m;
	logic        cs_n, wr_n, rd_n, hoe, s_out, s_oe, rdy_n, stb_n, pgnd, c_stb, c_start;
	aph_chan_t   mpos, mneg;
	aph_cmd_t    c_code;
	logic [15:0] rs = 16'h0037;
	logic [15:0] rb = 16'h0037;
	int          error_cnt = 0;
	int          checks = 0;
	int          cyc = 0;
	int          cnt_c = 0;
	int          cnt_f = 0;
	int          e;
	int          q[$];

	always #20 clk = ~clk;
	always @(negedge clk) flt <= ~flt;
	assign bus = (d_oe & d_out) | (~d_oe & (hoe ? hd : flt));

	aph_host_model h (.clk(clk), .strap(strap), .bus(bus), .cs_n(cs_n), .wr_n(wr_n),
		.rd_n(rd_n), .hoe(hoe), .hd(hd));

	aph_host_port dut (.CLK(clk), .RESET(rst), .WRITE_EDGE_SELECT_STRAP(strap), .CS_N(cs_n),
		.WR_N(wr_n), .RD_N(rd_n), .DATA_BUS_LINES_IN(bus), .DATA_BUS_LINES_OUT(d_out),
		.DATA_BUS_LINES_OE(d_oe), .DATA_INPUT_ENABLE(), .SYNC_IN(s_oe ? s_out : sync_in),
		.SYNC_OUT(s_out), .SYNC_OE(s_oe), .READY_N(rdy_n), .STANDBY_STATUS_N(stb_n),
		.MUX_POSITIVE_OUTPUT(mpos), .MUX_NEGATIVE_OUTPUT(mneg), .MUX_NEGATIVE_PSEUDO_GROUND(pgnd),
		.COMMAND_CODE(c_code), .COMMAND_STROBE(c_stb), .FUNCTION_DONE(fn_done),
		.CONV_START(c_start), .CONV_DONE(conv_done), .CONV_RESULT(conv_res));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmpw(input aph_word_t g, input aph_word_t x);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic cmpb(input logic g, input logic x);
		cmpw({12'h000, g}, {12'h000, x});
	endtask

	task automatic chk_mux(input logic [3:0] a);
		cmpw({10'h000, mpos}, {10'h000, a[2:0]});
		cmpb(pgnd, a[3]);
		if (!a[3])
			cmpw({10'h000, mneg}, {10'h000, a[2:1], ~a[0]});
	endtask

	task automatic wait_ready();
		for (int i = 0; i < 400 && rdy_n !== 1'b0; i++)
			@(negedge clk);
		cmpb(rdy_n, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////
	// Core model: fixed latencies; one timeout counter for the run
	always @(negedge clk) begin
		conv_done <= 1'b0;
		fn_done <= 1'b0;
		if (cnt_c == 1) begin
			rs = lfsr(rs);
			conv_res <= rs[12:0];
			conv_done <= 1'b1;
			q.push_back(int'(rs[12:0]));
		end
		if (cnt_f == 1)
			fn_done <= 1'b1;
		cnt_c <= c_start ? 20 : (cnt_c > 0 ? cnt_c - 1 : 0);
		cnt_f <= (c_stb && c_code inside {3'h1, 3'h2}) ? 30 : (cnt_f > 0 ? cnt_f - 1 : 0);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		for (int p = 0; p < 2; p++) begin
			rst = 1'b1;
			strap = ~p[0];
			h.slow = 3 * p;
			repeat (5) @(negedge clk);
			rst = 1'b0;
			repeat (3) @(negedge clk);
			cmpb(s_oe, 1'b0);
			cmpb(stb_n, 1'b0);
			h.rd(r, m);
			cmpw(m, 13'h00FF);
			cmpw(r & m, 13'h0000);
			rb = lfsr(rb);
			h.wr({5'h00, 4'hB, rb[3:0]});
			h.wr(13'h0008);
			chk_mux(rb[3:0]);
			cmpb(s_oe, 1'b1);
			wait_ready();
			rb = lfsr(rb);
			h.wr({5'h00, 4'h3, rb[3:0]});
			chk_mux(rb[3:0]);
			h.wr({5'h00, 4'hB, rb[3:0]});
			h.wr(13'h0006);
			cmpb(rdy_n, 1'b0);
			repeat (40) @(negedge clk);
			e = q[$];
			h.rd(r, m);
			cmpw(r & m, {5'h00, e[7:0]});
			h.rd(r, m);
			cmpw(r & m, {5'h00, {3{e[12]}}, e[12:8]});
			h.wr(13'h0080);
			h.wr(13'h0000);
			cmpb(stb_n, 1'b0);
			rb = lfsr(rb);
			h.wr(13'h00C0 | {9'h000, rb[3:0]});
			h.wr(13'h0019);
			chk_mux(rb[3:0]);
			cmpb(s_oe, 1'b0);
			cmpb(stb_n, 1'b1);
			repeat (90) @(negedge clk);
			sync_in = 1'b1;
			repeat (4) @(negedge clk);
			sync_in = 1'b0;
			wait_ready();
			h.rd(r, m);
			cmpw(m, 13'h1FFF);
			e = q[$];
			cmpw(r, e[12] ? 13'h0000 : aph_word_t'(e));
			h.wr(13'h1300);
			cmpb(rdy_n, 1'b1);
			wait_ready();
			$display("Pass %0d with strap %0d finished", p, strap);
		end
		final_report();
	end
endmodule
